// >>> design/conv_cfg.sv
// Converter configuration and result formatting block.
`timescale 1ns/1ps
`include "conv_cfg_defs.svh"
module conv_cfg
   import conv_cfg_pkg::*;
#(
   parameter int CODE_W = 10
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Special function register access
   input  wire sfr_req_t          sfr_req,
   output logic [7:0]             sfr_rdata,
   // Converter core
   input  wire logic              conv_start,
   input  wire logic              sar_bit,
   output logic                   conversion_clock_en,
   output logic                   converting,
   output logic                   conv_done,
   output logic                   input_gain_select,
   output logic                   byte_resolution_enable,
   output logic [CODE_W-1:0]      last_code
);

   //==========================================================================
   // Configuration register

   config_t cfg;
   config_t next_cfg;
   logic [7:0] result_low_byte;
   logic [7:0] result_high_byte;
   logic [7:0] next_result_low_byte;
   logic [7:0] next_result_high_byte;

   always_comb
   begin
      next_cfg = cfg;
      if (sfr_req.write && sfr_req.addr == `ADDR_CONFIG)
      begin
         next_cfg.divider                = sfr_req.wdata[`DIV_MSB:`DIV_LSB];
         next_cfg.left_justify_select    = sfr_req.wdata[`LJST_BIT];
         next_cfg.byte_resolution_enable = sfr_req.wdata[`BYTE_RES_BIT];
         next_cfg.input_gain_select      = sfr_req.wdata[`GAIN_BIT];
      end
   end

   assign input_gain_select      = cfg.input_gain_select;
   assign byte_resolution_enable = cfg.byte_resolution_enable;

   //==========================================================================
   // Conversion clock

   logic conv_tick;

   conv_clock_divider #(
      .DIV_W (5)
   ) u_div (
      .clk                (clk),
      .reset_n            (reset_n),
      .conv_clock_divider (cfg.divider),
      .conv_tick          (conv_tick)
   );

   assign conversion_clock_en = conv_tick;

   //==========================================================================
   // Successive approximation sequencing

   conv_state_t state;
   conv_state_t next_state;
   logic [3:0]        bit_count;
   logic [3:0]        next_bit_count;
   logic [CODE_W-1:0] code;
   logic [CODE_W-1:0] next_code;
   logic [CODE_W-1:0] next_last_code;
   logic              mode8;
   logic              next_mode8;

   // Resolution is latched at start so a mid-conversion write cannot mix formats.
   function automatic logic [3:0] conv_length(input logic byte_mode);
      conv_length = byte_mode ? (`BITS_10 - `BITS_SHORTER) : `BITS_10;
   endfunction

   always_comb
   begin
      next_state     = state;
      next_bit_count = bit_count;
      next_code      = code;
      next_mode8     = mode8;
      next_last_code = last_code;
      case (state)
         st_idle:
         begin
            if (conv_start)
            begin
               next_state     = st_convert;
               next_mode8     = cfg.byte_resolution_enable;
               next_bit_count = conv_length(cfg.byte_resolution_enable);
               next_code      = '0;
            end
         end
         st_convert:
         begin
            if (conv_tick)
            begin
               next_code = {code[CODE_W-2:0], sar_bit};
               next_bit_count = bit_count - 1'b1;
               if (bit_count == 4'h1)
                  next_state = st_done;
            end
         end
         st_done:
         begin
            // An 8-bit result is left-aligned into the 10-bit code width.
            next_last_code = mode8 ? {code[7:0], 2'b00} : code;
            next_state     = st_idle;
         end
         default:
            next_state = st_idle;
      endcase
   end

   assign converting = (state == st_convert);
   assign conv_done  = (state == st_done);

   //==========================================================================
   // Result formatting

   function automatic logic [15:0] format_result(input logic [CODE_W-1:0] c, input logic byte_mode,
                                                 input logic ljst);
      if (byte_mode)
         format_result = {c[CODE_W-1:CODE_W-8], 8'h00};
      else if (ljst)
         format_result = {c, 6'h00};
      else
         format_result = {6'h00, c};
   endfunction

   logic [15:0] formatted;

   always_comb
   begin
      formatted             = format_result(next_last_code, mode8, cfg.left_justify_select);
      next_result_high_byte = result_high_byte;
      next_result_low_byte  = result_low_byte;
      if (state == st_done)
      begin
         next_result_high_byte = formatted[15:8];
         next_result_low_byte  = formatted[7:0];
      end
      else if (sfr_req.write && sfr_req.addr == `ADDR_RESULT_HIGH)
         next_result_high_byte = sfr_req.wdata;
      else if (sfr_req.write && sfr_req.addr == `ADDR_RESULT_LOW)
         next_result_low_byte = sfr_req.wdata;
   end

   //==========================================================================
   // Read path

   logic [7:0] next_sfr_rdata;

   always_comb
   begin
      case (sfr_req.addr)
         `ADDR_CONFIG:      next_sfr_rdata = {cfg.divider, cfg.left_justify_select,
                                              cfg.byte_resolution_enable, cfg.input_gain_select};
         `ADDR_RESULT_LOW:  next_sfr_rdata = result_low_byte;
         `ADDR_RESULT_HIGH: next_sfr_rdata = result_high_byte;
         default:           next_sfr_rdata = 8'h00;
      endcase
   end

   //==========================================================================
   // Registers

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         cfg              <= config_t'(`CONFIG_RESET);
         result_low_byte  <= `RESULT_RESET;
         result_high_byte <= `RESULT_RESET;
         state            <= st_idle;
         bit_count        <= '0;
         code             <= '0;
         mode8            <= 1'b0;
         last_code        <= '0;
         sfr_rdata        <= 8'h00;
      end
      else
      begin
         cfg              <= next_cfg;
         result_low_byte  <= next_result_low_byte;
         result_high_byte <= next_result_high_byte;
         state            <= next_state;
         bit_count        <= next_bit_count;
         code             <= next_code;
         mode8            <= next_mode8;
         last_code        <= next_last_code;
         sfr_rdata        <= next_sfr_rdata;
      end
   end

   //==========================================================================
   // Checks

   sequence s_done;
      state == st_done;
   endsequence

   property p_load;
      @(posedge clk) disable iff (!reset_n)
      s_done ##0 (!mode8 && !cfg.left_justify_select) |=> result_high_byte == {6'h00, last_code[9:8]}
         && result_low_byte == last_code[7:0];
   endproperty
   a_load: assert property (p_load) else $error("right justify wrong");

   property p_left;
      @(posedge clk) disable iff (!reset_n)
      s_done ##0 (!mode8 && cfg.left_justify_select) |=> result_high_byte == last_code[9:2]
         && result_low_byte == {last_code[1:0], 6'h00};
   endproperty
   a_left: assert property (p_left) else $error("left justify wrong");

   property p_byte;
      @(posedge clk) disable iff (!reset_n)
      s_done ##0 mode8 |=> result_high_byte == last_code[9:2] && result_low_byte == 8'h00;
   endproperty
   a_byte: assert property (p_byte) else $error("byte mode wrong");

   property p_length;
      @(posedge clk) disable iff (!reset_n)
      (state == st_idle && conv_start && cfg.byte_resolution_enable) |=> bit_count == 4'h8;
   endproperty
   a_length: assert property (p_length) else $error("byte length wrong");

   property p_cfg_write;
      @(posedge clk) disable iff (!reset_n)
      (sfr_req.write && sfr_req.addr == `ADDR_CONFIG) |=> cfg.divider == $past(sfr_req.wdata[`DIV_MSB:`DIV_LSB])
         && input_gain_select == $past(sfr_req.wdata[`GAIN_BIT]);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

   property p_tick_gate;
      @(posedge clk) disable iff (!reset_n)
      (state == st_convert && !conv_tick) |=> $stable(code);
   endproperty
   a_tick_gate: assert property (p_tick_gate) else $error("bit taken without clock");

   property p_res;
      @(posedge clk) disable iff (!reset_n)
      (state == st_idle && conv_start) |=> mode8 == $past(cfg.byte_resolution_enable);
   endproperty
   a_res: assert property (p_res) else $error("resolution not latched");

   property p_ignore;
      @(posedge clk) disable iff (!reset_n)
      s_done ##0 mode8 |=> result_low_byte == 8'h00;
   endproperty
   a_ignore: assert property (p_ignore) else $error("justify not ignored");

   property p_bits_ten;
      @(posedge clk) disable iff (!reset_n)
      (state == st_idle && conv_start && !cfg.byte_resolution_enable) |=> bit_count == `BITS_10;
   endproperty
   a_bits_ten: assert property (p_bits_ten) else $error("word length wrong");

   property p_finish;
      @(posedge clk) disable iff (!reset_n)
      (state == st_convert && conv_tick && bit_count == 4'h1) |=> s_done;
   endproperty
   a_finish: assert property (p_finish) else $error("conversion did not finish");

   property p_done_pulse;
      @(posedge clk) disable iff (!reset_n)
      s_done |=> !conv_done && !converting;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

   // Results must hold between loads so software reads both bytes of one code.
   property p_result_hold;
      @(posedge clk) disable iff (!reset_n)
      (!conv_done && !sfr_req.write) |=> $stable(result_high_byte) && $stable(result_low_byte);
   endproperty
   a_result_hold: assert property (p_result_hold) else $error("result changed without a load");

   property p_cfg_hold;
      @(posedge clk) disable iff (!reset_n)
      !(sfr_req.write && sfr_req.addr == `ADDR_CONFIG) |=> $stable(cfg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without a write");

   property p_read_config;
      @(posedge clk) disable iff (!reset_n)
      (sfr_req.addr == `ADDR_CONFIG) |=> sfr_rdata == $past(cfg);
   endproperty
   a_read_config: assert property (p_read_config) else $error("config read wrong");

   property p_read_high;
      @(posedge clk) disable iff (!reset_n)
      (sfr_req.addr == `ADDR_RESULT_HIGH) |=> sfr_rdata == $past(result_high_byte);
   endproperty
   a_read_high: assert property (p_read_high) else $error("high byte read wrong");

   property p_read_low;
      @(posedge clk) disable iff (!reset_n)
      (sfr_req.addr == `ADDR_RESULT_LOW) |=> sfr_rdata == $past(result_low_byte);
   endproperty
   a_read_low: assert property (p_read_low) else $error("low byte read wrong");

endmodule

// >>> design/conv_cfg_defs.svh
// Register offsets, field positions, reset values and timing counts of the converter configuration block.
//==============================================================================
`ifndef CONV_CFG_DEFS_SVH
`define CONV_CFG_DEFS_SVH

`define ADDR_CONFIG      8'hbc
`define ADDR_RESULT_LOW  8'hbd
`define ADDR_RESULT_HIGH 8'hbe

`define DIV_MSB          7
`define DIV_LSB          3
`define LJST_BIT         2
`define BYTE_RES_BIT     1
`define GAIN_BIT         0

`define CONFIG_RESET     8'hf8
`define RESULT_RESET     8'h00
`define DIV_MIN_MPC      5'h01

`define BITS_10          4'ha
`define BITS_SHORTER     4'h2

`endif

// >>> design/conv_cfg_pkg.sv
// Types shared by the converter configuration block.
package conv_cfg_pkg;

   typedef struct packed
   {
      logic       write;
      logic       read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef struct packed
   {
      logic [4:0] divider;
      logic       left_justify_select;
      logic       byte_resolution_enable;
      logic       input_gain_select;
   } config_t;

   typedef enum logic [1:0]
   {
      st_idle,
      st_convert,
      st_done
   } conv_state_t;

endpackage

// >>> design/conv_clock_divider.sv
// Divider that derives the conversion clock enable from the system clock.
`timescale 1ns/1ps
`include "conv_cfg_defs.svh"
module conv_clock_divider
   import conv_cfg_pkg::*;
#(
   parameter int DIV_W = 5
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // Divider setting
   input  wire logic [DIV_W-1:0] conv_clock_divider,
   // Conversion clock
   output logic                  conv_tick
);

   logic [DIV_W-1:0] count;
   logic [DIV_W-1:0] next_count;
   logic [DIV_W-1:0] last_div;
   logic [DIV_W-1:0] next_last_div;

   // A change of divider restarts the count so no stretched period follows.
   always_comb
   begin
      next_last_div = conv_clock_divider;
      if (conv_clock_divider != last_div)
         next_count = '0;
      else if (count >= conv_clock_divider)
         next_count = '0;
      else
         next_count = count + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         count    <= '0;
         last_div <= '0;
      end
      else
      begin
         count    <= next_count;
         last_div <= next_last_div;
      end
   end

   assign conv_tick = (count >= conv_clock_divider) && (conv_clock_divider == last_div);

   // The spacing is only judged while the field stays put; a rewrite restarts the count on purpose.
   property p_tick_spacing;
      @(posedge clk) disable iff (!reset_n)
      (conv_tick && conv_clock_divider == DIV_W'(1)) ##1 (conv_clock_divider == DIV_W'(1)) [*2]
         |-> conv_tick && !$past(conv_tick);
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("divider period wrong");

   property p_reload;
      @(posedge clk) disable iff (!reset_n)
      (conv_clock_divider != last_div) |=> (count == '0);
   endproperty
   a_reload: assert property (p_reload) else $error("divider did not reload");

endmodule

// >>> dv/sar_core_model.sv
// Behavioural converter core that answers each bit decision of a conversion.
`timescale 1ns/1ps
module sar_core_model
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Converter handshake
   input  wire logic       conv_start,
   input  wire logic       conversion_clock_en,
   input  wire logic       converting,
   input  wire logic [9:0] code,
   // Comparator decision
   output logic            sar_bit
);
   //===========================================================================
   // Bit sequencing
   logic [3:0] idx;
   logic       idle_pattern = 1'b0;

   // Between conversions the comparator output wanders, so it toggles here.
   assign sar_bit = converting ? code[idx] : idle_pattern;

   always @(posedge clk)
   begin
      idle_pattern <= ~idle_pattern;
      if (!reset_n || conv_start)
         idx <= 4'h9;
      else if (converting && conversion_clock_en)
         idx <= idx - 4'h1;
   end
endmodule

// >>> dv/conv_cfg_tb_top.sv
// Self-checking testbench of the converter configuration block.
`timescale 1ns/1ps
`include "conv_cfg_defs.svh"
module conv_cfg_tb_top
   import conv_cfg_pkg::*;
();
   //===========================================================================
   // Stimulus and observation
   logic       clk = 1'b0;
   logic       reset_n = 1'b0;
   sfr_req_t   req = '0;
   logic [7:0] sfr_rdata;
   logic       conv_start = 1'b0;
   logic       sar_bit;
   logic       conversion_clock_en;
   logic       converting;
   logic       conv_done;
   logic       input_gain_select;
   logic       byte_resolution_enable;
   logic [9:0] last_code;
   logic [9:0] model_code = 10'h000;
   int         num_errors = 0;
   int         comparisons = 0;

   always #20 clk = ~clk;

   conv_cfg conv_cfg_i
   (
      .clk                    (clk),
      .reset_n                (reset_n),
      .sfr_req                (req),
      .sfr_rdata              (sfr_rdata),
      .conv_start             (conv_start),
      .sar_bit                (sar_bit),
      .conversion_clock_en    (conversion_clock_en),
      .converting             (converting),
      .conv_done              (conv_done),
      .input_gain_select      (input_gain_select),
      .byte_resolution_enable (byte_resolution_enable),
      .last_code              (last_code)
   );

   sar_core_model sar_core_model_i
   (
      .clk                 (clk),
      .reset_n             (reset_n),
      .conv_start          (conv_start),
      .conversion_clock_en (conversion_clock_en),
      .converting          (converting),
      .code                (model_code),
      .sar_bit             (sar_bit)
   );

   //===========================================================================
   // Shared tasks
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req.write = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge clk);
      req.write = 1'b0;
   endtask

   // Read data is registered, so it is taken one cycle after the address.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      req.read = 1'b1;
      req.addr = a;
      @(negedge clk);
      d = sfr_rdata;
      req.read = 1'b0;
   endtask

   task automatic wait_tick(output int n);
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (conversion_clock_en !== 1'b1 && n < 100);
      if (n >= 100)
      begin
         num_errors++;
         conclude();
      end
   endtask

   //===========================================================================
   // Scenarios
   task automatic test_reset();
      logic [7:0] v;
      rd(`ADDR_CONFIG, v);
      chk("config reset", 10'h0f8, 10'(v));
      rd(`ADDR_RESULT_LOW, v);
      chk("low reset", 10'h000, 10'(v));
      rd(`ADDR_RESULT_HIGH, v);
      chk("high reset", 10'h000, 10'(v));
      chk("gain reset", 10'h000, 10'(input_gain_select));
      wr(`ADDR_RESULT_HIGH, 8'h5a);
      wr(8'hbf, 8'hff);
      rd(`ADDR_RESULT_HIGH, v);
      chk("high write", 10'h05a, 10'(v));
      rd(`ADDR_CONFIG, v);
      chk("config after unmapped write", 10'h0f8, 10'(v));
      rd(8'hbf, v);
      chk("unmapped read", 10'h000, 10'(v));
      $display("reset test done");
   endtask

   task automatic test_divider();
      int n;
      int d [4] = '{0, 1, 3, 31};
      foreach (d[i])
      begin
         wr(`ADDR_CONFIG, {5'(d[i]), 3'h0});
         wait_tick(n);
         chk("first tick after reload", 10'(d[i] + 1), 10'(n));
         wait_tick(n);
         chk("tick period", 10'(d[i] + 1), 10'(n));
      end
      $display("divider test done");
   endtask

   task automatic run_conv(input logic ljst, input logic bm, input logic gain, input logic [9:0] code);
      logic [7:0] hi;
      logic [7:0] lo;
      int         n;
      int         ticks;
      wr(`ADDR_CONFIG, {5'h01, ljst, bm, gain});
      model_code = code;
      @(negedge clk);
      conv_start = 1'b1;
      @(negedge clk);
      conv_start = 1'b0;
      ticks = 0;
      for (n = 0; n < 2000 && conv_done !== 1'b1; n++)
      begin
         ticks += (conversion_clock_en && converting) ? 1 : 0;
         @(negedge clk);
      end
      if (n >= 2000)
      begin
         num_errors++;
         conclude();
      end
      rd(`ADDR_RESULT_HIGH, hi);
      rd(`ADDR_RESULT_LOW, lo);
      chk("result high", (ljst | bm) ? 10'(code[9:2]) : 10'(code[9:8]), 10'(hi));
      chk("result low", bm ? 10'h000 : ljst ? 10'({code[1:0], 6'h00}) : 10'(code[7:0]), 10'(lo));
      chk("ticks", bm ? 10'h008 : 10'h00a, 10'(ticks));
      chk("last code", bm ? {code[9:2], 2'h0} : code, last_code);
      chk("gain", 10'(gain), 10'(input_gain_select));
      chk("byte mode", 10'(bm), 10'(byte_resolution_enable));
   endtask

   task automatic test_formats();
      run_conv(1'b0, 1'b0, 1'b1, 10'h2b6);
      run_conv(1'b1, 1'b0, 1'b0, 10'h2b6);
      run_conv(1'b0, 1'b1, 1'b1, 10'h1c9);
      run_conv(1'b1, 1'b1, 1'b0, 10'h1c9);
      run_conv(1'b1, 1'b0, 1'b1, 10'h3ff);
      $display("format test done");
   endtask

   initial
   begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      test_reset();
      test_divider();
      test_formats();
      conclude();
   end
endmodule
